// *** hw/ddsl_pkg.sv ***
// Constants and types for the dual converter serial load block
package ddsl_pkg;

   //---------------------------------------------------------------
   // Serial word layout
   //---------------------------------------------------------------
   localparam int          WORD_BITS  = 16;
   localparam int          CNT_W      = 5;
   localparam int          CODE_BITS  = 12;
   localparam int          SEL_POS    = 15;
   localparam int          SD_POS     = 13;
   localparam int          ZERO_POS   = 12;
   localparam int          CODE_MSB   = 11;
   localparam logic [4:0]  LAST_EDGE  = 5'h0F;

   // Two's complement zero sits this far above the unsigned bottom
   localparam logic [11:0] MID_OFS    = 12'h800;
   localparam logic [11:0] CODE_ZERO  = 12'h000;

   //---------------------------------------------------------------
   // Register map
   //---------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  ADDR_CTRL  = 8'h00;
   localparam logic [7:0]  ADDR_STAT  = 8'h04;
   localparam logic [7:0]  ADDR_CODEA = 8'h08;
   localparam logic [7:0]  ADDR_CODEB = 8'h0C;
   localparam logic [7:0]  ADDR_WORDS = 8'h10;
   localparam int          CTRL_EN    = 0;
   localparam logic        CTRL_RST   = 1'b1;
   localparam int          STAT_PD    = 0;
   localparam int          STAT_OWNER = 1;
   localparam int          STAT_B12   = 2;
   localparam int          STAT_BUSY  = 3;
   localparam int          STAT_CNT   = 8;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
   localparam logic [2:0]  PIN_RST    = 3'h2;

   //---------------------------------------------------------------
   // Frame states
   //---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      DDSL_IDLE  = 3'b001,
      DDSL_SHIFT = 3'b010,
      DDSL_DONE  = 3'b100
   } ddsl_state_e;

endpackage : ddsl_pkg

// *** hw/ddsl_sync.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module ddsl_sync
#(
   parameter int         WIDTH = 3,
   parameter logic [2:0] RST   = 3'h0
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Pins and result
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] dout_next;

   // First stage is read only by the second
   always_comb
   begin
      meta_next = din;
      dout_next = meta_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= RST[WIDTH-1:0];
         dout     <= RST[WIDTH-1:0];
      end
      else
      begin
         meta_reg <= meta_next;
         dout     <= dout_next;
      end
   end

endmodule : ddsl_sync

// *** hw/ddsl_chan.sv ***
// One converter channel: code register, offset output and enable
`timescale 1ns/10ps
module ddsl_chan
(
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   // Load from the serial word
   input  wire logic                                load,
   input  wire logic [ddsl_pkg::CODE_BITS-1:0]      code_in,
   input  wire logic                                pd,
   // Channel state
   output logic      [ddsl_pkg::CODE_BITS-1:0]      code,
   output logic      [ddsl_pkg::CODE_BITS-1:0]      out_code,
   output logic                                     out_oe_n
);
   import ddsl_pkg::*;

   logic [CODE_BITS-1:0] code_next;
   logic [CODE_BITS-1:0] out_next;
   logic                 oe_n_next;

   // Code updates even in shutdown so release shows the new value
   always_comb
   begin
      code_next = code;
      if (load)
         code_next = code_in;
      out_next  = code + MID_OFS;
      oe_n_next = pd;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code     <= CODE_ZERO;
         out_code <= MID_OFS;
         out_oe_n <= 1'b0;
      end
      else
      begin
         code     <= code_next;
         out_code <= out_next;
         out_oe_n <= oe_n_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_reset_midscale: assert property ($rose(rst_n) |-> code == CODE_ZERO && out_code == MID_OFS)
      else $error("channel not at midscale after reset");
   chk_offset_code: assert property (load |=> ##1 out_code == 12'($past(code_in, 2) + MID_OFS))
      else $error("output code not offset from loaded code");
   chk_load_while_down: assert property (pd && load |=> code == $past(code_in) && out_oe_n)
      else $error("code not stored during shutdown");
   chk_float_down: assert property (pd |=> out_oe_n)
      else $error("output driven during shutdown");

endmodule : ddsl_chan

// *** hw/ddsl_top.sv ***
// Serial load and shutdown control for a dual 12-bit converter
//-------------------------------------------------------------------
//-------------------------------------------------------------------
`timescale 1ns/10ps
module ddsl_top
(
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   // Serial link pins
   input  wire logic                              sclk,
   input  wire logic                              cs_n,
   input  wire logic                              serial_in,
   // Converter outputs
   output logic      [ddsl_pkg::CODE_BITS-1:0]    dac_a_code,
   output logic      [ddsl_pkg::CODE_BITS-1:0]    dac_b_code,
   output logic                                   dac_a_oe_n,
   output logic                                   dac_b_oe_n,
   output logic                                   bipolar_zero_oe_n,
   output logic                                   ref_enable,
   // AXI4-Lite write channels
   input  wire logic [ddsl_pkg::ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic      [1:0]                        s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ddsl_pkg::ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic      [31:0]                       s_axi_rdata,
   output logic      [1:0]                        s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready
);
   import ddsl_pkg::*;

   //----------------------------------------------------------------
   // Pin synchronisation
   //----------------------------------------------------------------
   logic [2:0] pins_s;
   logic       sclk_s;
   logic       cs_n_s;
   logic       sin_s;

   // Select idles high so a reset never looks like a frame start
   ddsl_sync #(.WIDTH(3), .RST(PIN_RST)) u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({sclk, cs_n, serial_in}),
      .dout  (pins_s)
   );
   assign {sclk_s, cs_n_s, sin_s} = pins_s;

   //----------------------------------------------------------------
   // Serial frame engine
   //----------------------------------------------------------------
   ddsl_state_e          state_reg;
   ddsl_state_e          state_next;
   logic                 sclk_d_reg;
   logic                 sclk_d_next;
   logic [WORD_BITS-1:0] sr_reg;
   logic [WORD_BITS-1:0] sr_next;
   logic [CNT_W-1:0]     cnt_reg;
   logic [CNT_W-1:0]     cnt_next;
   logic                 load_reg;
   logic                 load_next;
   logic [WORD_BITS-1:0] word_reg;
   logic [WORD_BITS-1:0] word_next;
   logic                 rise;
   logic                 go_frame;
   logic                 shift_ok;
   logic                 en_reg;

   // Edge finding and frame counting on the sampled serial clock
   always_comb
   begin
      rise        = sclk_s & ~sclk_d_reg;
      go_frame    = ~cs_n_s & en_reg & (state_reg == DDSL_IDLE);
      shift_ok    = ~cs_n_s & ((state_reg == DDSL_SHIFT) | go_frame);
      sclk_d_next = sclk_s;
      state_next  = state_reg;
      sr_next     = sr_reg;
      cnt_next    = cnt_reg;
      load_next   = 1'b0;
      word_next   = word_reg;
      case (state_reg)
         DDSL_IDLE:
            if (go_frame)
               state_next = DDSL_SHIFT;
         DDSL_SHIFT:
            state_next = DDSL_SHIFT;
         DDSL_DONE:
            state_next = DDSL_DONE;
         default:
            state_next = DDSL_IDLE;
      endcase
      if (rise && shift_ok)
      begin
         sr_next  = {sr_reg[WORD_BITS-2:0], sin_s};
         cnt_next = CNT_W'(cnt_reg + 1'b1);
         if (cnt_reg == LAST_EDGE)
         begin
            load_next  = 1'b1;
            word_next  = sr_next;
            state_next = DDSL_DONE;
         end
      end
      if (cs_n_s)
      begin
         state_next = DDSL_IDLE;
         cnt_next   = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg  <= DDSL_IDLE;
         sclk_d_reg <= 1'b0;
         sr_reg     <= '0;
         cnt_reg    <= '0;
         load_reg   <= 1'b0;
         word_reg   <= '0;
      end
      else
      begin
         state_reg  <= state_next;
         sclk_d_reg <= sclk_d_next;
         sr_reg     <= sr_next;
         cnt_reg    <= cnt_next;
         load_reg   <= load_next;
         word_reg   <= word_next;
      end
   end

   //----------------------------------------------------------------
   // Shutdown and status
   //----------------------------------------------------------------
   logic        pd_reg;
   logic        pd_next;
   logic        owner_reg;
   logic        owner_next;
   logic        b12_reg;
   logic        b12_next;
   logic [15:0] words_reg;
   logic [15:0] words_next;
   logic        ref_next;
   logic        bz_next;
   logic        b12_clr;

   // Bit 14 is never looked at; a set of bit 12 beats a clear
   always_comb
   begin
      pd_next    = pd_reg;
      owner_next = owner_reg;
      b12_next   = b12_reg & ~b12_clr;
      words_next = words_reg;
      if (load_reg)
      begin
         words_next = words_reg + 16'h0001;
         if (word_reg[ZERO_POS])
            b12_next = 1'b1;
         if (word_reg[SD_POS])
         begin
            if (!pd_reg)
            begin
               pd_next    = 1'b1;
               owner_next = word_reg[SEL_POS];
            end
         end
         else if (word_reg[SEL_POS] == owner_reg)
            pd_next = 1'b0;
      end
      ref_next = ~pd_reg;
      bz_next  = pd_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pd_reg            <= 1'b0;
         owner_reg         <= 1'b0;
         b12_reg           <= 1'b0;
         words_reg         <= '0;
         ref_enable        <= 1'b1;
         bipolar_zero_oe_n <= 1'b0;
      end
      else
      begin
         pd_reg            <= pd_next;
         owner_reg         <= owner_next;
         b12_reg           <= b12_next;
         words_reg         <= words_next;
         ref_enable        <= ref_next;
         bipolar_zero_oe_n <= bz_next;
      end
   end

   //----------------------------------------------------------------
   // Converter channels
   //----------------------------------------------------------------
   logic [CODE_BITS-1:0] code_a;
   logic [CODE_BITS-1:0] code_b;

   ddsl_chan u_chan_a
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (load_reg & ~word_reg[SEL_POS]),
      .code_in  (word_reg[CODE_MSB:0]),
      .pd       (pd_reg),
      .code     (code_a),
      .out_code (dac_a_code),
      .out_oe_n (dac_a_oe_n)
   );

   ddsl_chan u_chan_b
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (load_reg & word_reg[SEL_POS]),
      .code_in  (word_reg[CODE_MSB:0]),
      .pd       (pd_reg),
      .code     (code_b),
      .out_code (dac_b_code),
      .out_oe_n (dac_b_oe_n)
   );

   //----------------------------------------------------------------
   // AXI4-Lite write side
   //----------------------------------------------------------------
   logic              aw_have_reg;
   logic              aw_have_next;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [ADDR_W-1:0] aw_addr_next;
   logic              w_have_reg;
   logic              w_have_next;
   logic [31:0]       w_data_reg;
   logic [31:0]       w_data_next;
   logic              w_lane0_reg;
   logic              w_lane0_next;
   logic              awready_next;
   logic              wready_next;
   logic              bvalid_next;
   logic [1:0]        bresp_next;
   logic              en_next;

   // Address and data may come in either order; respond after both
   always_comb
   begin
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next  = w_have_reg;
      w_data_next  = w_data_reg;
      w_lane0_next = w_lane0_reg;
      bvalid_next  = s_axi_bvalid;
      bresp_next   = s_axi_bresp;
      en_next      = en_reg;
      b12_clr      = 1'b0;
      if (s_axi_bvalid && s_axi_bready)
         bvalid_next = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_next  = 1'b1;
         w_data_next  = s_axi_wdata;
         w_lane0_next = s_axi_wstrb[0];
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid)
      begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         case (aw_addr_reg)
            ADDR_CTRL:
               if (w_lane0_reg)
                  en_next = w_data_reg[CTRL_EN];
            ADDR_STAT:
               b12_clr = w_lane0_reg & w_data_reg[STAT_B12];
            ADDR_CODEA, ADDR_CODEB, ADDR_WORDS:
               bresp_next = RESP_OKAY;
            default:
               bresp_next = RESP_SLV;
         endcase
      end
      awready_next = ~aw_have_next & ~bvalid_next;
      wready_next  = ~w_have_next & ~bvalid_next;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have_reg   <= 1'b0;
         aw_addr_reg   <= '0;
         w_have_reg    <= 1'b0;
         w_data_reg    <= '0;
         w_lane0_reg   <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         en_reg        <= CTRL_RST;
      end
      else
      begin
         aw_have_reg   <= aw_have_next;
         aw_addr_reg   <= aw_addr_next;
         w_have_reg    <= w_have_next;
         w_data_reg    <= w_data_next;
         w_lane0_reg   <= w_lane0_next;
         s_axi_awready <= awready_next;
         s_axi_wready  <= wready_next;
         s_axi_bvalid  <= bvalid_next;
         s_axi_bresp   <= bresp_next;
         en_reg        <= en_next;
      end
   end

   //----------------------------------------------------------------
   // AXI4-Lite read side
   //----------------------------------------------------------------
   logic        arready_next;
   logic        rvalid_next;
   logic [1:0]  rresp_next;
   logic [31:0] rdata_next;

   // Unmapped reads return zero with a slave error
   always_comb
   begin
      rvalid_next = s_axi_rvalid;
      rresp_next  = s_axi_rresp;
      rdata_next  = s_axi_rdata;
      if (s_axi_rvalid && s_axi_rready)
         rvalid_next = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         rdata_next  = '0;
         case (s_axi_araddr)
            ADDR_CTRL:
               rdata_next[CTRL_EN] = en_reg;
            ADDR_STAT:
            begin
               rdata_next[STAT_PD]    = pd_reg;
               rdata_next[STAT_OWNER] = owner_reg;
               rdata_next[STAT_B12]   = b12_reg;
               rdata_next[STAT_BUSY]  = state_reg == DDSL_SHIFT;
               rdata_next[STAT_CNT +: CNT_W] = cnt_reg;
            end
            ADDR_CODEA:
               rdata_next[CODE_MSB:0] = code_a;
            ADDR_CODEB:
               rdata_next[CODE_MSB:0] = code_b;
            ADDR_WORDS:
               rdata_next[15:0] = words_reg;
            default:
               rresp_next = RESP_SLV;
         endcase
      end
      arready_next = ~rvalid_next;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
      end
      else
      begin
         s_axi_arready <= arready_next;
         s_axi_rvalid  <= rvalid_next;
         s_axi_rresp   <= rresp_next;
         s_axi_rdata   <= rdata_next;
      end
   end

   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_shift_edge;
      rise && shift_ok;
   endsequence

   sequence seq_last_edge;
      rise && shift_ok && cnt_reg == LAST_EDGE;
   endsequence

   sequence seq_load_a;
      load_reg && !word_reg[SEL_POS];
   endsequence

   chk_shift_one_bit: assert property (seq_shift_edge |=> sr_reg == {$past(sr_reg[14:0]), $past(sin_s)})
      else $error("shift did not take exactly one bit");
   chk_select_high_hold: assert property (cs_n_s |=> $stable(sr_reg))
      else $error("shift register moved while select high");
   chk_load_on_last: assert property (seq_last_edge ##1 seq_load_a |=> code_a == $past(word_reg[11:0]))
      else $error("channel A not loaded after 16th edge");
   chk_done_ignores: assert property (state_reg == DDSL_DONE && !cs_n_s |=> $stable(sr_reg) && !load_reg)
      else $error("edge accepted after word complete");
   chk_shutdown_entry: assert property (load_reg && word_reg[SD_POS] |=> pd_reg ##1 !ref_enable && bipolar_zero_oe_n)
      else $error("shutdown word did not power down");
   chk_release_same: assert property (load_reg && !word_reg[SD_POS] && word_reg[SEL_POS] == owner_reg |=> !pd_reg)
      else $error("matching clear word did not release");
   chk_release_other: assert property (load_reg && pd_reg && word_reg[SEL_POS] != owner_reg |=> pd_reg)
      else $error("other channel word released shutdown");

endmodule : ddsl_top

// *** sim/ddsl_host.sv ***
// Behavioural host controller that frames serial words
`timescale 1ns/10ps
module ddsl_host
(
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      serial_in
);
   // Idle link: select high, clock still
   initial
   begin
      sclk      = 1'b0;
      cs_n      = 1'b1;
      serial_in = 1'b0;
   end

   // Send top n bits of w, then keep select low for hold cycles
   task automatic send(input logic [19:0] w, input int n, input int hold);
      repeat (4) @(posedge clk);
      cs_n <= 1'b0;
      // MSB first, data steady across each rise
      for (int i = 19; i > 19 - n; i--)
      begin
         repeat (4) @(posedge clk);
         serial_in <= w[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (hold) @(posedge clk);
      // Select raised after the last edge
      cs_n      <= 1'b1;
      serial_in <= ~serial_in; // Released line must not look valid
   endtask : send
endmodule : ddsl_host

// *** sim/tb.sv ***
// Self-checking bench for the serial load and shutdown block
`timescale 1ns/10ps
module tb;
   import ddsl_pkg::*;
   // Design pins and bench state
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sclk, cs_n, serial_in;
   logic [11:0] dac_a_code, dac_b_code, sa, sb, c;
   logic        dac_a_oe_n, dac_b_oe_n, bipolar_zero_oe_n, ref_enable;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
   wire  [3:0]  pins = {dac_a_oe_n, dac_b_oe_n, bipolar_zero_oe_n, ref_enable};
   int          n_fail = 0;
   int          n_checks = 0;

   always #5 clk = ~clk;
   ddsl_top  i_dut (.*);
   ddsl_host i_host (.clk, .sclk, .cs_n, .serial_in);

   // Unsigned output code for a stored two's complement value
   function automatic logic [11:0] ofs(input logic [11:0] v);
      return v + MID_OFS;
   endfunction : ofs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // A wait that ran out ends the run
   task automatic guard(input int t);
      if (t >= 50)
      begin
         chk(32'h0, 32'h1);
         tally_and_finish;
      end
   endtask : guard

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (t = 0; t < 50; t++)
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      rd_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      guard(t);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int t;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (t = 0; t < 50; t++)
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      guard(t);
   endtask : rd

   // Main sequence
   initial
   begin
      void'($urandom(32'h2AAD6B99));
      sa = 12'h000;
      sb = 12'h000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(dac_a_code, 12'h800);
      chk(dac_b_code, 12'h800);
      chk(pins, 4'h1);
      // Random loads on both channels, end codes first
      for (int k = 0; k < 10; k++)
      begin
         c = (k == 0) ? 12'h7FF : (k == 1) ? 12'h800 : 12'($urandom);
         i_host.send({k[0], 1'($urandom), 2'b00, c, 4'h0}, 16, 8);
         if (k[0])
            sb = c;
         else
            sa = c;
         chk(dac_a_code, ofs(sa));
         chk(dac_b_code, ofs(sb));
      end
      // Edges past the sixteenth leave the word alone
      sa = 12'($urandom);
      i_host.send({4'h0, sa, 4'hF}, 20, 8);
      chk(dac_a_code, ofs(sa));
      // Shutdown on A; a B clear keeps it, an A clear ends it
      sa = 12'h123;
      i_host.send({4'h2, sa, 4'h0}, 16, 8);
      chk(pins, 4'hE);
      rd(ADDR_STAT);
      chk(rd_d[1:0], 2'b01);
      sb = 12'h456;
      i_host.send({4'h8, sb, 4'h0}, 16, 8);
      chk(pins, 4'hE);
      chk(dac_b_code, ofs(sb));
      i_host.send({4'h0, sa, 4'h0}, 16, 8);
      chk(pins, 4'h1);
      // Stored codes, fourteen loaded words and an idle, clean status
      rd(ADDR_CODEA);
      chk(rd_d, {20'h0, sa});
      rd(ADDR_CODEB);
      chk(rd_d, {20'h0, sb});
      rd(ADDR_WORDS);
      chk(rd_d, 32'hE);
      rd(ADDR_STAT);
      chk(rd_d, 32'h0);
      // Frames refused while the serial enable is off
      wr(ADDR_CTRL, 32'h0);
      i_host.send({4'h0, ~sa, 4'h0}, 16, 8);
      chk(dac_a_code, ofs(sa));
      wr(ADDR_CTRL, 32'h1);
      // Reset in mid-run drops a B shutdown and returns midscale
      i_host.send({4'hA, sb, 4'h0}, 16, 8);
      chk(pins, 4'hE);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(dac_a_code, 12'h800);
      chk(dac_b_code, 12'h800);
      chk(pins, 4'h1);
      // Unmapped address answers with an error
      rd(8'hFC);
      chk(rd_r, RESP_SLV);
      wr(8'hFC, 32'h0);
      chk(rd_r, RESP_SLV);
      tally_and_finish;
   end
endmodule : tb
